// ==== logic/cpmf_cfg.svh ====
// timing constants and delay-slot indices for the cell protection mode controller
`ifndef CPMF_CFG_SVH
`define CPMF_CFG_SVH

`define CPMF_CLK_MHZ      250
`define CPMF_CNT_W        24

// detection and release delays in microseconds
`define CPMF_T_DOC1_US    10000
`define CPMF_T_SC_US      250
`define CPMF_T_DOCR_US    1000
`define CPMF_T_COCH_US    8000
`define CPMF_T_COCHR_US   1000

// delay-slot indices
`define CPMF_DLY_N        5
`define CPMF_DLY_DOC1     0
`define CPMF_DLY_SC       1
`define CPMF_DLY_DOCR     2
`define CPMF_DLY_COCH     3
`define CPMF_DLY_COCHR    4

`endif

// ==== logic/cpmf_pkg.sv ====
// types for the cell protection mode controller
package cpmf_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_DOC1,
    MODE_SC,
    MODE_COCH,
    MODE_ZEROV
  } cpmf_mode_e;

  // comparator and presence levels from the analog front end
  typedef struct packed {
    logic doc1_hit;         // sense >= first discharge threshold
    logic sc_hit;           // sense >= short_circuit_threshold
    logic docr_ok;          // sense <= discharge release threshold
    logic coch_hit;         // sense <= charge over-current threshold
    logic cochr_ok;         // sense >= charge release threshold
    logic load_present;
    logic charger_present;
    logic cell_depleted;    // cell below over-discharge release level
    logic charger_start_ok; // charger at or above charge-start level
    logic cell_uvr_ok;      // cell at or above over-discharge release level
  } cpmf_in_s;

  typedef struct packed {
    logic charge_switch;
    logic discharge_switch;
    logic sense_pulldown;
  } cpmf_out_s;

  typedef struct packed {
    logic [23:0] cnt;
  } cpmf_dly_s;

  typedef struct packed {
    cpmf_in_s   sync1;
    cpmf_in_s   sync2;
    cpmf_mode_e mode;
    cpmf_out_s  outs;
  } cpmf_st_s;

endpackage

// ==== logic/cpmf_delay.sv ====
// restartable hold-time counter for one comparator condition
`timescale 1ns/1ns
`include "cpmf_cfg.svh"

module cpmf_delay #(
  parameter logic [`CPMF_CNT_W-1:0] CYC = 24'h000001
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // condition and result
  input  wire logic cond,
  output logic      done
);

  cpmf_pkg::cpmf_dly_s st_r;
  cpmf_pkg::cpmf_dly_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!cond) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt != CYC) begin
      st_nxt.cnt = st_r.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // done in the cycle the condition completes CYC consecutive cycles
  assign done = cond && (st_r.cnt >= CYC - 24'h000001);

  AST_DELAY_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    !cond |=> st_r.cnt == '0 && !done)
    else $error("delay counter did not restart");

endmodule

// ==== logic/cpmf_top.sv ====
// mode controller for a single-cell protection device: switches and sense pull-down
`timescale 1ns/1ns
`include "cpmf_cfg.svh"

module cpmf_top #(
  parameter int unsigned DOC1_CYC  = `CPMF_T_DOC1_US * `CPMF_CLK_MHZ,
  parameter int unsigned SC_CYC    = `CPMF_T_SC_US * `CPMF_CLK_MHZ,
  parameter int unsigned DOCR_CYC  = `CPMF_T_DOCR_US * `CPMF_CLK_MHZ,
  parameter int unsigned COCH_CYC  = `CPMF_T_COCH_US * `CPMF_CLK_MHZ,
  parameter int unsigned COCHR_CYC = `CPMF_T_COCHR_US * `CPMF_CLK_MHZ
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // analog comparator and presence levels, asynchronous
  input  wire cpmf_pkg::cpmf_in_s  levels,
  // power switch and pull-down drive
  output cpmf_pkg::cpmf_out_s      drive,
  // current mode, for observation
  output cpmf_pkg::cpmf_mode_e     mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  cpmf_pkg::cpmf_st_s st_r;
  cpmf_pkg::cpmf_st_s st_nxt;
  cpmf_pkg::cpmf_in_s lv;

  logic [`CPMF_DLY_N-1:0] dly_cond;
  logic [`CPMF_DLY_N-1:0] dly_done;

  localparam logic [`CPMF_DLY_N-1:0][`CPMF_CNT_W-1:0] DLY_CYC = {
    COCHR_CYC[`CPMF_CNT_W-1:0],
    COCH_CYC[`CPMF_CNT_W-1:0],
    DOCR_CYC[`CPMF_CNT_W-1:0],
    SC_CYC[`CPMF_CNT_W-1:0],
    DOC1_CYC[`CPMF_CNT_W-1:0]
  };

  // only the second synchroniser stage feeds logic
  assign lv = st_r.sync2;

  ////////////////////////////////////////////////////////////////////////////
  // delay counters, armed only in the mode that uses them

  always_comb begin
    dly_cond = '0;
    if (st_r.mode == cpmf_pkg::MODE_NORMAL) begin
      dly_cond[`CPMF_DLY_DOC1] = lv.doc1_hit;
      dly_cond[`CPMF_DLY_SC]   = lv.sc_hit;
      dly_cond[`CPMF_DLY_COCH] = lv.coch_hit;
    end
    if (st_r.mode == cpmf_pkg::MODE_DOC1 || st_r.mode == cpmf_pkg::MODE_SC) begin
      dly_cond[`CPMF_DLY_DOCR] = !lv.load_present && lv.docr_ok;
    end
    if (st_r.mode == cpmf_pkg::MODE_COCH) begin
      // charger gone lifts the sense pin by itself
      dly_cond[`CPMF_DLY_COCHR] = !lv.charger_present && lv.cochr_ok;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CPMF_DLY_N; gi++) begin : g_dly
      cpmf_delay #(
        .CYC (DLY_CYC[gi])
      ) u_dly (
        .clk   (clk),
        .rst_n (rst_n),
        .cond  (dly_cond[gi]),
        .done  (dly_done[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode transitions and outputs

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = levels;
    st_nxt.sync2 = st_r.sync1;
    unique case (st_r.mode)
      cpmf_pkg::MODE_NORMAL: begin
        // short circuit outranks the slower detections
        if (dly_done[`CPMF_DLY_SC]) begin
          st_nxt.mode = cpmf_pkg::MODE_SC;
        end else if (dly_done[`CPMF_DLY_DOC1]) begin
          st_nxt.mode = cpmf_pkg::MODE_DOC1;
        end else if (dly_done[`CPMF_DLY_COCH]) begin
          st_nxt.mode = cpmf_pkg::MODE_COCH;
        end else if (lv.cell_depleted) begin
          st_nxt.mode = cpmf_pkg::MODE_ZEROV;
        end
      end
      cpmf_pkg::MODE_DOC1: begin
        if (dly_done[`CPMF_DLY_DOCR]) begin
          st_nxt.mode = cpmf_pkg::MODE_NORMAL;
        end
      end
      cpmf_pkg::MODE_SC: begin
        if (dly_done[`CPMF_DLY_DOCR]) begin
          st_nxt.mode = cpmf_pkg::MODE_NORMAL;
        end
      end
      cpmf_pkg::MODE_COCH: begin
        if (dly_done[`CPMF_DLY_COCHR]) begin
          st_nxt.mode = cpmf_pkg::MODE_NORMAL;
        end
      end
      cpmf_pkg::MODE_ZEROV: begin
        if (lv.cell_uvr_ok) begin
          st_nxt.mode = cpmf_pkg::MODE_NORMAL;
        end
      end
      default: begin
        st_nxt.mode = cpmf_pkg::MODE_NORMAL;
      end
    endcase

    // outputs follow the next mode so they change with it
    st_nxt.outs = '{charge_switch: 1'b1, discharge_switch: 1'b1, sense_pulldown: 1'b0};
    unique case (st_nxt.mode)
      cpmf_pkg::MODE_NORMAL: begin
      end
      cpmf_pkg::MODE_DOC1: begin
        st_nxt.outs.discharge_switch = 1'b0;
        st_nxt.outs.sense_pulldown   = 1'b1;
      end
      cpmf_pkg::MODE_SC: begin
        st_nxt.outs.discharge_switch = 1'b0;
        st_nxt.outs.sense_pulldown   = 1'b1;
      end
      cpmf_pkg::MODE_COCH: begin
        st_nxt.outs.charge_switch = 1'b0;
      end
      cpmf_pkg::MODE_ZEROV: begin
        // charge flows through the discharge switch body diode
        st_nxt.outs.charge_switch    = lv.charger_start_ok;
        st_nxt.outs.discharge_switch = 1'b0;
      end
      default: begin
        st_nxt.outs.charge_switch = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.mode <= cpmf_pkg::MODE_NORMAL;
      st_r.outs <= '{charge_switch: 1'b1, discharge_switch: 1'b1, sense_pulldown: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive = st_r.outs;
  assign mode  = st_r.mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_DOC1_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_DOC1 && dly_done[`CPMF_DLY_DOCR]
    |=> st_r.mode == cpmf_pkg::MODE_NORMAL && drive.discharge_switch)
    else $error("discharge mode 1 did not release");

  AST_DOC1_HOLD_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_DOC1 && lv.load_present
    |=> st_r.mode == cpmf_pkg::MODE_DOC1)
    else $error("discharge mode 1 left with load present");

  AST_SC_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_NORMAL && dly_done[`CPMF_DLY_SC]
    |=> st_r.mode == cpmf_pkg::MODE_SC && !drive.discharge_switch)
    else $error("short circuit not entered");

  AST_SC_PULLDOWN: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_SC |-> drive.sense_pulldown)
    else $error("pull-down off in short circuit");

  AST_SC_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_SC && !dly_done[`CPMF_DLY_DOCR]
    |=> st_r.mode == cpmf_pkg::MODE_SC && !drive.discharge_switch)
    else $error("short circuit left early");

  AST_COCH_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_NORMAL && dly_done[`CPMF_DLY_COCH]
    && !dly_done[`CPMF_DLY_SC] && !dly_done[`CPMF_DLY_DOC1]
    |=> !drive.charge_switch)
    else $error("charge over-current not entered");

  AST_COCH_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_COCH && lv.charger_present
    |=> st_r.mode == cpmf_pkg::MODE_COCH && !drive.charge_switch)
    else $error("charge over-current left with charger present");

  AST_ZEROV_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_ZEROV
    |-> !drive.discharge_switch && drive.charge_switch == $past(lv.charger_start_ok))
    else $error("zero-volt drive wrong");

  AST_ZEROV_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_ZEROV && lv.cell_uvr_ok
    |=> st_r.mode == cpmf_pkg::MODE_NORMAL)
    else $error("zero-volt charging did not end");

  AST_DOC1_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_NORMAL && dly_done[`CPMF_DLY_DOC1] && !dly_done[`CPMF_DLY_SC]
    |=> !drive.discharge_switch && drive.sense_pulldown)
    else $error("discharge mode 1 not entered");

  AST_NORMAL_ON: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.mode == cpmf_pkg::MODE_NORMAL
    |-> drive.charge_switch && drive.discharge_switch && !drive.sense_pulldown)
    else $error("switch off in normal mode");

  AST_RESET_STATE: assert property (@(posedge clk)
    $rose(rst_n) |-> st_r.mode == cpmf_pkg::MODE_NORMAL && dly_done == '0)
    else $error("bad state after reset");

endmodule

// ==== verif/cpmf_pack_model.sv ====
// behavioural charger, load and cell on the pack terminals, giving comparator levels
`timescale 1ns/1ns

module cpmf_pack_model (
  // stimulus from the bench
  input  wire logic                load_on,
  input  wire logic                charger_on,
  input  wire logic [1:0]          amps,
  input  wire logic                cell_low,
  input  wire logic                cell_up,
  input  wire logic                start_ok,
  // device drive and resulting levels
  input  wire cpmf_pkg::cpmf_out_s drive,
  output cpmf_pkg::cpmf_in_s       levels
);
  // amps: 0 quiet, 1 overload, 2 short, 3 charge overcurrent
  // current only flows through a closed switch, so an open switch quiets the sense
  always_comb begin
    levels.doc1_hit         = load_on & drive.discharge_switch & (amps == 2'h1 || amps == 2'h2);
    levels.sc_hit           = load_on & drive.discharge_switch & (amps == 2'h2);
    levels.docr_ok          = ~load_on;
    levels.coch_hit         = charger_on & drive.charge_switch & (amps == 2'h3);
    // internal current lifts the sense as soon as the charger is gone
    levels.cochr_ok         = ~charger_on;
    levels.load_present     = load_on;
    levels.charger_present  = charger_on;
    levels.cell_depleted    = cell_low;
    levels.charger_start_ok = charger_on & start_ok;
    levels.cell_uvr_ok      = cell_up;
  end
endmodule

// ==== verif/cpmf_top_bench.sv ====
// self-checking bench for the cell protection mode controller
`timescale 1ns/1ns

module cpmf_top_bench;
  // short delays keep the run brief; every expectation except the zero-volt ones derives from these
  localparam int DOC1_N  = 4;
  localparam int SC_N    = 2;
  localparam int DOCR_N  = 3;
  localparam int COCH_N  = 5;
  localparam int COCHR_N = 3;
  typedef struct packed {
    cpmf_pkg::cpmf_mode_e mode;
    cpmf_pkg::cpmf_out_s  drv;
    logic [31:0]          cyc;
  } cpmf_note_s;
  logic                 clk        = 1'b0;
  logic                 rst_n      = 1'b0;
  logic                 load_on    = 1'b0;
  logic                 charger_on = 1'b0;
  logic                 cell_low   = 1'b0;
  logic                 cell_up    = 1'b1;
  logic                 start_ok   = 1'b0;
  logic [1:0]           amps       = 2'h0;
  logic [31:0]          cyc        = 32'h0;
  int                   n_errors   = 0;
  int                   cmp_count  = 0;
  int                   g;
  cpmf_pkg::cpmf_in_s   levels;
  cpmf_pkg::cpmf_out_s  drive;
  cpmf_pkg::cpmf_mode_e mode;
  cpmf_pkg::cpmf_mode_e last_mode  = cpmf_pkg::MODE_NORMAL;
  cpmf_note_s           notes[$];
  cpmf_note_s           nt;

  cpmf_top #(.DOC1_CYC(DOC1_N), .SC_CYC(SC_N), .DOCR_CYC(DOCR_N), .COCH_CYC(COCH_N),
             .COCHR_CYC(COCHR_N)) uut (.clk(clk), .rst_n(rst_n), .levels(levels),
             .drive(drive), .mode(mode));
  cpmf_pack_model pack (.load_on(load_on), .charger_on(charger_on), .amps(amps),
                        .cell_low(cell_low), .cell_up(cell_up), .start_ok(start_ok),
                        .drive(drive), .levels(levels));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    // generous ceiling: the whole sequence needs well under 300 cycles
    if (cyc == 32'h0000_0bb8) begin
      n_errors++;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // cycle all ones means the moment is not checked
  task automatic expect_at(input cpmf_pkg::cpmf_mode_e m, input logic [2:0] d,
                           input logic [31:0] c);
    notes.push_back('{m, cpmf_pkg::cpmf_out_s'(d), c});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100 && notes.size() != 0; i++) @(negedge clk);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // monitor: every mode change consumes the oldest note; a change with none queued is wrong
  always @(negedge clk) begin
    if (rst_n === 1'b1 && mode !== last_mode) begin
      if (notes.size() == 0) begin
        check({29'h0, mode}, {29'h0, last_mode});
      end else begin
        nt = notes.pop_front();
        check({26'h0, mode, drive}, {26'h0, nt.mode, nt.drv});
        if (nt.cyc !== 32'hffffffff) check(cyc, nt.cyc);
      end
    end
    last_mode <= mode;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(68));
    settle(2);
    rst_n = 1'b1;
    settle(1);
    check({29'h0, mode}, {29'h0, cpmf_pkg::MODE_NORMAL});
    check({29'h0, drive}, 32'h6);
    // overload that drops once short of the delay must restart the count
    g = 1 + $urandom % (DOC1_N - 1);
    load_on = 1'b1;
    amps = 2'h1;
    settle(g);
    amps = 2'h0;
    settle(1);
    amps = 2'h1;
    // two synchroniser edges, then n counted cycles, then the mode register
    expect_at(cpmf_pkg::MODE_DOC1, 3'h5, cyc + DOC1_N + 2);
    wait_idle();
    amps = 2'h0;
    settle(10);
    load_on = 1'b0;
    expect_at(cpmf_pkg::MODE_NORMAL, 3'h6, cyc + DOCR_N + 2);
    wait_idle();
    // short circuit and its release
    load_on = 1'b1;
    amps = 2'h2;
    expect_at(cpmf_pkg::MODE_SC, 3'h5, cyc + SC_N + 2);
    wait_idle();
    load_on = 1'b0;
    amps = 2'h0;
    expect_at(cpmf_pkg::MODE_NORMAL, 3'h6, cyc + DOCR_N + 2);
    wait_idle();
    // charge overcurrent holds while the charger stays
    charger_on = 1'b1;
    amps = 2'h3;
    expect_at(cpmf_pkg::MODE_COCH, 3'h2, cyc + COCH_N + 2);
    wait_idle();
    amps = 2'h0;
    settle(10);
    charger_on = 1'b0;
    expect_at(cpmf_pkg::MODE_NORMAL, 3'h6, cyc + COCHR_N + 2);
    wait_idle();
    // depleted cell: charge follows the start level, discharge stays off
    cell_low = 1'b1;
    cell_up = 1'b0;
    charger_on = 1'b1;
    expect_at(cpmf_pkg::MODE_ZEROV, 3'h0, cyc + 3);
    wait_idle();
    start_ok = 1'b1;
    settle(4);
    check({29'h0, drive}, 32'h4);
    cell_low = 1'b0;
    cell_up = 1'b1;
    expect_at(cpmf_pkg::MODE_NORMAL, 3'h6, cyc + 3);
    wait_idle();
    settle(4);
    check(notes.size(), 32'h0);
    results();
  end
endmodule
